/* design/dbx_pkg.sv */
// constants and types for the debug exception unit
package dbx_pkg;
  typedef enum logic [1:0] {
    MODE_16 = 2'h0,
    MODE_32 = 2'h1,
    MODE_64 = 2'h2
  } dbx_mode_t;
  localparam int NUM_BP = 4;
  localparam logic [7:0] OFF_BP_LAST = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_CONTROL = 8'h24;
  localparam logic [7:0] OFF_STATE = 8'h28;
  localparam logic [2:0] IDX_STATUS = 3'h6;
  localparam logic [2:0] IDX_CONTROL = 3'h7;
  localparam int STAT_BD = 13;
  localparam int STAT_BS = 14;
  localparam int STAT_BT = 15;
  localparam int CTL_GD = 13;
  localparam int CTL_COND_LSB = 16;
  localparam int CTL_LEN_LSB = 18;
  localparam int CTL_STRIDE = 4;
  localparam logic [31:0] STATUS_MASK = 32'h0000_e00f;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
  localparam logic [1:0] COND_EXEC = 2'h0;
  localparam logic [1:0] COND_WRITE = 2'h1;
  localparam logic [1:0] COND_IO = 2'h2;
  localparam logic [1:0] COND_RW = 2'h3;
  localparam logic [1:0] LEN_1 = 2'h0;
  localparam logic [1:0] LEN_2 = 2'h1;
  localparam logic [1:0] LEN_8 = 2'h2;
  localparam logic [1:0] LEN_4 = 2'h3;
  localparam logic [63:0] MASK_2B = 64'h0000_0000_0000_0001;
  localparam logic [63:0] MASK_4B = 64'h0000_0000_0000_0003;
  localparam logic [63:0] MASK_8B = 64'h0000_0000_0000_0007;
  localparam logic [7:0] VEC_DEBUG = 8'h01;
  localparam logic [7:0] VEC_BP = 8'h03;
  localparam logic [7:0] VEC_GP = 8'h0d;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* design/dbx_unit.sv */
// debug exception condition logic with axi4-lite register access
`timescale 1ns/1ps
module dbx_unit (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // core mode and debug register moves
  input dbx_pkg::dbx_mode_t mode,
  input wire logic mov_valid,
  input wire logic mov_write,
  input wire logic [2:0] mov_idx,
  input wire logic [63:0] mov_wdata,
  output logic mov_rvalid,
  output logic [63:0] mov_rdata,
  // instruction flow
  input wire logic insn_start,
  input wire logic [63:0] insn_addr,
  input wire logic insn_end,
  input wire logic ss_load,
  input wire logic rep_nonfinal,
  // data and i/o accesses
  input wire logic dacc_valid,
  input wire logic [63:0] dacc_addr,
  input wire logic [1:0] dacc_len,
  input wire logic dacc_write,
  input wire logic dacc_io,
  // other events
  input wire logic single_step,
  input wire logic task_switch,
  input wire logic hw_trap_instr,
  input wire logic sw_bp_instr,
  input wire logic fault_req,
  input wire logic [7:0] fault_vector,
  input wire logic hw_int,
  input wire logic [7:0] int_vector,
  // resume flag load
  input wire logic rf_load,
  input wire logic rf_image,
  // exception request to the core
  output logic exc_valid,
  output logic [7:0] exc_vector,
  output logic exc_fault,
  output logic exc_has_err,
  output logic exc_pushed_rf,
  output logic resume_flag
);

  logic [63:0] bp_addr_reg [dbx_pkg::NUM_BP];
  logic [31:0] status_reg, status_next, status_set, ctl_reg;
  logic rf_reg, ss_inhibit_reg, pend_reg;
  logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic axi_wr, axi_rd, ax_st_wr, sw_status_wr;
  logic [3:0] ibp_match, dbp_match;
  logic ibp_fire, gd_fire, gp_fire, mov_exec, trap_now;
  logic [63:0] mov_wval, mov_rval;
  logic [31:0] rd_val;
  logic rd_err, wr_err;
  logic ev, ev_flt, ev_err, ev_prf, ev_dbg_trap;
  logic [7:0] ev_vec;
  logic exc_valid_reg, exc_fault_reg, exc_err_reg, exc_prf_reg;
  logic [7:0] exc_vec_reg;
  logic mov_rvalid_reg;
  logic [63:0] mov_rdata_reg;

  function automatic logic [63:0] len_mask(input logic [1:0] len);
    case (len)
      dbx_pkg::LEN_2: len_mask = dbx_pkg::MASK_2B;
      dbx_pkg::LEN_4: len_mask = dbx_pkg::MASK_4B;
      dbx_pkg::LEN_8: len_mask = dbx_pkg::MASK_8B;
      default: len_mask = '0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // per-breakpoint address match
  for (genvar n = 0; n < dbx_pkg::NUM_BP; n++) begin : g_bp
    logic [1:0] cond, len;
    logic en, ovl;
    logic [63:0] lo, hi, ahi;
    assign cond = ctl_reg[dbx_pkg::CTL_COND_LSB + dbx_pkg::CTL_STRIDE*n +: 2];
    assign len = ctl_reg[dbx_pkg::CTL_LEN_LSB + dbx_pkg::CTL_STRIDE*n +: 2];
    assign en = ctl_reg[2*n] | ctl_reg[2*n+1];
    assign lo = bp_addr_reg[n] & ~len_mask(len);
    assign hi = lo | len_mask(len);
    assign ahi = dacc_addr + len_mask(dacc_len);
    assign ovl = (dacc_addr <= hi) && (ahi >= lo);
    assign ibp_match[n] = en && cond == dbx_pkg::COND_EXEC
      && insn_addr == bp_addr_reg[n];
    assign dbp_match[n] = en && dacc_valid && ovl && (dacc_io ?
      cond == dbx_pkg::COND_IO : (cond == dbx_pkg::COND_RW
      || (cond == dbx_pkg::COND_WRITE && dacc_write)));
  end

  // condition detection
  assign ibp_fire = insn_start && (|ibp_match) && !rf_reg
    && !ss_inhibit_reg;
  assign gd_fire = mov_valid && !ibp_fire && ctl_reg[dbx_pkg::CTL_GD];
  assign gp_fire = mov_valid && !ibp_fire && !gd_fire && mov_write
    && mode == dbx_pkg::MODE_64 && mov_idx[2:1] == 2'h3
    && (|mov_wdata[63:32]);
  assign mov_exec = mov_valid && !ibp_fire && !gd_fire && !gp_fire;
  assign trap_now = (insn_end && (pend_reg || (|dbp_match)))
    || single_step || task_switch || hw_trap_instr;

  // move data width by mode
  assign mov_wval = (mode == dbx_pkg::MODE_64) ? mov_wdata
    : {32'h0000_0000, mov_wdata[31:0]};
  always_comb begin
    case (mov_idx)
      3'h0, 3'h1, 3'h2, 3'h3: mov_rval = bp_addr_reg[mov_idx[1:0]];
      dbx_pkg::IDX_STATUS: mov_rval = {32'h0000_0000, status_reg};
      dbx_pkg::IDX_CONTROL: mov_rval = {32'h0000_0000, ctl_reg};
      default: mov_rval = '0;
    endcase
    if (mode != dbx_pkg::MODE_64) begin
      mov_rval[63:32] = 32'h0000_0000;
    end
  end

  // exception selection, highest priority first
  always_comb begin
    ev = 1'b1;
    ev_vec = dbx_pkg::VEC_DEBUG;
    ev_flt = 1'b1;
    ev_err = 1'b0;
    ev_prf = 1'b1;
    ev_dbg_trap = 1'b0;
    if (ibp_fire) begin
      ev_prf = rf_reg;
    end else if (gd_fire) begin
      ev_prf = 1'b1;
    end else if (gp_fire) begin
      ev_vec = dbx_pkg::VEC_GP;
      ev_err = 1'b1;
    end else if (fault_req) begin
      ev_vec = fault_vector;
    end else if (trap_now) begin
      ev_flt = 1'b0;
      ev_dbg_trap = 1'b1;
      ev_prf = rep_nonfinal | rf_reg;
    end else if (sw_bp_instr) begin
      ev_vec = dbx_pkg::VEC_BP;
      ev_flt = 1'b0;
      ev_prf = rf_reg;
    end else if (hw_int) begin
      ev_vec = int_vector;
      ev_flt = 1'b0;
      ev_prf = rep_nonfinal | rf_reg;
    end else begin
      ev = 1'b0;
      ev_flt = 1'b0;
      ev_prf = 1'b0;
    end
  end

  // sticky status bits
  always_comb begin
    status_set = '0;
    status_set[3:0] = (ibp_fire ? ibp_match : 4'h0) | dbp_match;
    status_set[dbx_pkg::STAT_BD] = gd_fire;
    status_set[dbx_pkg::STAT_BS] = single_step;
    status_set[dbx_pkg::STAT_BT] = task_switch;
  end

  assign ax_st_wr = axi_wr && aw_addr_reg == dbx_pkg::OFF_STATUS;
  assign sw_status_wr = ax_st_wr
    || (mov_exec && mov_write && mov_idx == dbx_pkg::IDX_STATUS);
  always_comb begin
    status_next = status_reg;
    if (ax_st_wr) begin
      status_next = merge(status_reg, w_data_reg, w_strb_reg)
        & dbx_pkg::STATUS_MASK;
    end
    if (mov_exec && mov_write && mov_idx == dbx_pkg::IDX_STATUS) begin
      status_next = mov_wval[31:0] & dbx_pkg::STATUS_MASK;
    end
    status_next = status_next | status_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= dbx_pkg::STATUS_RST;
    end else begin
      status_reg <= status_next;
    end
  end

  // control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_reg <= dbx_pkg::CONTROL_RST;
    end else begin
      if (axi_wr && aw_addr_reg == dbx_pkg::OFF_CONTROL) begin
        ctl_reg <= merge(ctl_reg, w_data_reg, w_strb_reg);
      end
      if (mov_exec && mov_write && mov_idx == dbx_pkg::IDX_CONTROL) begin
        ctl_reg <= mov_wval[31:0];
      end
      if (ev && ev_vec == dbx_pkg::VEC_DEBUG) begin
        ctl_reg[dbx_pkg::CTL_GD] <= 1'b0;
      end
    end
  end

  // breakpoint address registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < dbx_pkg::NUM_BP; i++) begin
        bp_addr_reg[i] <= '0;
      end
    end else begin
      if (axi_wr && aw_addr_reg <= dbx_pkg::OFF_BP_LAST) begin
        if (aw_addr_reg[2]) begin
          bp_addr_reg[aw_addr_reg[4:3]][63:32] <= merge(
            bp_addr_reg[aw_addr_reg[4:3]][63:32], w_data_reg, w_strb_reg);
        end else begin
          bp_addr_reg[aw_addr_reg[4:3]][31:0] <= merge(
            bp_addr_reg[aw_addr_reg[4:3]][31:0], w_data_reg, w_strb_reg);
        end
      end
      if (mov_exec && mov_write && !mov_idx[2]) begin
        bp_addr_reg[mov_idx[1:0]] <= mov_wval;
      end
    end
  end

  // resume flag, stack load shadow, pending data breakpoint
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rf_reg <= 1'b0;
    end else if (rf_load) begin
      rf_reg <= rf_image;
    end else if (insn_start) begin
      rf_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ss_inhibit_reg <= 1'b0;
    end else if (insn_end && ss_load) begin
      ss_inhibit_reg <= 1'b1;
    end else if (insn_start) begin
      ss_inhibit_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg <= 1'b0;
    end else if (ev && (ev_flt || ev_dbg_trap)) begin
      pend_reg <= 1'b0;
    end else if (|dbp_match) begin
      pend_reg <= 1'b1;
    end
  end

  // exception and move outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exc_valid_reg <= 1'b0;
      exc_vec_reg <= 8'h00;
      exc_fault_reg <= 1'b0;
      exc_err_reg <= 1'b0;
      exc_prf_reg <= 1'b0;
      mov_rvalid_reg <= 1'b0;
      mov_rdata_reg <= '0;
    end else begin
      exc_valid_reg <= ev;
      exc_vec_reg <= ev ? ev_vec : 8'h00;
      exc_fault_reg <= ev_flt;
      exc_err_reg <= ev_err;
      exc_prf_reg <= ev_prf;
      mov_rvalid_reg <= mov_exec && !mov_write;
      if (mov_exec && !mov_write) begin
        mov_rdata_reg <= mov_rval;
      end
    end
  end

  // axi4-lite write path
  assign axi_wr = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_err = aw_addr_reg > dbx_pkg::OFF_STATE;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= '0;
      w_strb_reg <= 4'h0;
      bresp_reg <= dbx_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (axi_wr) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_err ? dbx_pkg::RESP_SLVERR : dbx_pkg::RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // axi4-lite read path
  assign axi_rd = s_axi_arvalid && !rvalid_reg;
  always_comb begin
    rd_err = 1'b0;
    rd_val = '0;
    if (s_axi_araddr <= dbx_pkg::OFF_BP_LAST) begin
      rd_val = s_axi_araddr[2] ? bp_addr_reg[s_axi_araddr[4:3]][63:32]
        : bp_addr_reg[s_axi_araddr[4:3]][31:0];
    end else if (s_axi_araddr[7:2] == dbx_pkg::OFF_STATUS[7:2]) begin
      rd_val = status_reg;
    end else if (s_axi_araddr[7:2] == dbx_pkg::OFF_CONTROL[7:2]) begin
      rd_val = ctl_reg;
    end else if (s_axi_araddr[7:2] == dbx_pkg::OFF_STATE[7:2]) begin
      rd_val = {27'h000_0000, mode, pend_reg, ss_inhibit_reg, rf_reg};
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= dbx_pkg::RESP_OKAY;
    end else if (axi_rd) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_val;
      rresp_reg <= rd_err ? dbx_pkg::RESP_SLVERR : dbx_pkg::RESP_OKAY;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign exc_valid = exc_valid_reg;
  assign exc_vector = exc_vec_reg;
  assign exc_fault = exc_fault_reg;
  assign exc_has_err = exc_err_reg;
  assign exc_pushed_rf = exc_prf_reg;
  assign resume_flag = rf_reg;
  assign mov_rvalid = mov_rvalid_reg;
  assign mov_rdata = mov_rdata_reg;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_narrow_read;
    mov_valid && !mov_write && mode != dbx_pkg::MODE_64 && !insn_start
      && !ctl_reg[dbx_pkg::CTL_GD] |=> mov_rvalid && mov_rdata[63:32] == 0;
  endproperty
  a_narrow_read: assert property (p_narrow_read)
    else $error("upper half not zero on narrow read");

  property p_gp_upper;
    mov_valid && mov_write && mode == dbx_pkg::MODE_64 && !insn_start
      && mov_idx == dbx_pkg::IDX_CONTROL && (|mov_wdata[63:32])
      && !ctl_reg[dbx_pkg::CTL_GD] |=> exc_valid && exc_has_err
      && exc_vector == dbx_pkg::VEC_GP && ctl_reg == $past(ctl_reg);
  endproperty
  a_gp_upper: assert property (p_gp_upper)
    else $error("reserved upper write did not fault");

  property p_ibp_fault;
    insn_start && (|ibp_match) && !rf_reg && !ss_inhibit_reg
      |=> exc_valid && exc_fault && exc_vector == dbx_pkg::VEC_DEBUG
      && !exc_pushed_rf && (status_reg[3:0] & $past(ibp_match)) != 0;
  endproperty
  a_ibp_fault: assert property (p_ibp_fault)
    else $error("instruction breakpoint not raised");

  property p_rf_masks;
    insn_start && rf_reg && !mov_valid && !fault_req
      |=> !(exc_valid && exc_fault);
  endproperty
  a_rf_masks: assert property (p_rf_masks)
    else $error("breakpoint taken with resume flag set");

  property p_rf_clear;
    insn_start && !rf_load |=> !resume_flag;
  endproperty
  a_rf_clear: assert property (p_rf_clear)
    else $error("resume flag not cleared at instruction start");

  property p_rf_load;
    rf_load |=> resume_flag == $past(rf_image);
  endproperty
  a_rf_load: assert property (p_rf_load)
    else $error("resume flag not loaded from image");

  property p_fault_rf;
    fault_req && !insn_start && !mov_valid
      |=> exc_valid && exc_fault && exc_pushed_rf;
  endproperty
  a_fault_rf: assert property (p_fault_rf)
    else $error("fault pushed resume flag 0");

  property p_ss_sticky;
    single_step ##1 !sw_status_wr [*3] |-> status_reg[dbx_pkg::STAT_BS];
  endproperty
  a_ss_sticky: assert property (p_ss_sticky)
    else $error("single step flag lost");

  property p_ss_shadow;
    insn_end && ss_load && !rf_load ##1 insn_start |=> !exc_fault;
  endproperty
  a_ss_shadow: assert property (p_ss_shadow)
    else $error("breakpoint not suppressed after stack load");
endmodule

/* tb/dbx_unit_bench.sv */
// self-checking bench for the debug exception unit
`timescale 1ns/1ps
module dbx_unit_bench;
  logic aclk = 1'b0;
  logic rstn = 1'b0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0] awa = 0, ara = 0, fv = 0, iv = 0, evec;
  logic [31:0] wd = 0, rd, d;
  logic awr, wr_rdy, bv, arr, rv, mrv, ev, ef, eh, erf, rf;
  logic [1:0] br, rr, r;
  logic [1:0] dl = 0;
  dbx_pkg::dbx_mode_t mode = dbx_pkg::MODE_64;
  logic mw = 0, rep = 0, dw = 0, rfi = 0, dio = 0;
  logic [2:0] mi = 0;
  logic [63:0] mwd = 0, ia = 0, da = 0, mrd, a, x;
  // pulses: 0 start 1 end 2 ssload 3 dacc 4 step 5 tsw 6 hwtrap
  // 7 swbp 8 fault 9 hwint 10 rfload 11 move
  logic [11:0] p = 0;
  logic [15:0] lfsr = 16'h819d;
  logic [31:0] m_stat = 0;
  int failures = 0, num_checks = 0, cyc = 0;
  dbx_unit u_dbx_unit (.aclk(aclk), .aresetn(rstn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .mode(mode), .mov_valid(p[11]),
    .mov_write(mw), .mov_idx(mi), .mov_wdata(mwd), .mov_rvalid(mrv),
    .mov_rdata(mrd), .insn_start(p[0]), .insn_addr(ia), .insn_end(p[1]),
    .ss_load(p[2]), .rep_nonfinal(rep), .dacc_valid(p[3]),
    .dacc_addr(da), .dacc_len(dl), .dacc_write(dw), .dacc_io(dio),
    .single_step(p[4]), .task_switch(p[5]), .hw_trap_instr(p[6]),
    .sw_bp_instr(p[7]), .fault_req(p[8]), .fault_vector(fv),
    .hw_int(p[9]), .int_vector(iv), .rf_load(p[10]), .rf_image(rfi),
    .exc_valid(ev), .exc_vector(evec), .exc_fault(ef),
    .exc_has_err(eh), .exc_pushed_rf(erf), .resume_flag(rf));
  always #12.5 aclk = ~aclk;
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
    return {lfsr, lfsr ^ 16'ha5a5};
  endfunction
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish;
    end
  end
  task check(input string n, input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge aclk);
    awv <= 1;
    wv <= 1;
    awa <= ad;
    wd <= dt;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 0;
      if (wv && wr_rdy) wv <= 0;
    end while ((awv && !awr) || (wv && !wr_rdy));
    bry <= 1;
    do @(posedge aclk); while (!bv);
    r = br;
    bry <= 0;
  endtask
  task rdr(input logic [7:0] ad);
    @(posedge aclk);
    arv <= 1;
    ara <= ad;
    rry <= 1;
    do @(posedge aclk); while (!arr);
    arv <= 0;
    do @(posedge aclk); while (!rv);
    d = rd;
    r = rr;
    rry <= 0;
  endtask
  task fire(input logic [11:0] m);
    p <= m;
    @(posedge aclk);
    p <= '0;
    #1;
  endtask
  task exp_exc(input logic v, input logic [7:0] vec, input logic f,
               input logic e, input logic prf);
    check("exc_valid", ev, v);
    if (v) begin
      check("exc_vector", evec, vec);
      check("exc_fault", ef, f);
      check("exc_has_err", eh, e);
      check("exc_pushed_rf", erf, prf);
    end
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    rstn <= 1;
    a = {rnd(), rnd()};
    wr(8'h00, a[31:0]);
    wr(8'h04, a[63:32]);
    rdr(8'h04);
    check("bp0_high", d, a[63:32]);
    rdr(8'h40);
    check("unmapped_rresp", {r, d}, {dbx_pkg::RESP_SLVERR, 32'h0});
    wr(8'h40, 32'hffff_ffff);
    check("unmapped_bresp", r, dbx_pkg::RESP_SLVERR);
    wr(8'h28, 32'hffff_ffff);
    rdr(8'h28);
    check("state", d, 32'h0000_0010);
    x = {rnd(), rnd()};
    @(posedge aclk);
    mode <= dbx_pkg::MODE_32;
    mw <= 1;
    mi <= 3'h1;
    mwd <= x;
    fire(12'h800);
    mw <= 0;
    fire(12'h800);
    check("mov32_rvalid", mrv, 1'b1);
    check("mov32", mrd, {32'h0, x[31:0]});
    @(posedge aclk);
    mode <= dbx_pkg::MODE_64;
    mw <= 1;
    mi <= 3'h2;
    fire(12'h800);
    mw <= 0;
    fire(12'h800);
    check("mov64_rvalid", mrv, 1'b1);
    check("mov64", mrd, x);
    mode <= dbx_pkg::MODE_32;
    fire(12'h800);
    check("mov_narrow", mrd, {32'h0, x[31:0]});
    mode <= dbx_pkg::MODE_64;
    @(posedge aclk);
    mw <= 1;
    mi <= dbx_pkg::IDX_CONTROL;
    mwd <= 64'h0000_0001_0000_0000;
    fire(12'h800);
    exp_exc(1, dbx_pkg::VEC_GP, 1, 1, 1);
    rdr(8'h24);
    check("ctl_kept", d, 32'h0);
    wr(8'h24, 32'h0090_0005);
    wr(8'h08, 32'h0000_1000);
    wr(8'h0c, 32'h0);
    @(posedge aclk);
    ia <= a;
    fire(12'h001);
    exp_exc(1, dbx_pkg::VEC_DEBUG, 1, 0, 0);
    m_stat[0] = 1;
    @(posedge aclk);
    rfi <= 1;
    fire(12'h400);
    check("rf_loaded", rf, 1'b1);
    fire(12'h001);
    exp_exc(0, 0, 0, 0, 0);
    check("rf_cleared", rf, 1'b0);
    fire(12'h001);
    exp_exc(1, dbx_pkg::VEC_DEBUG, 1, 0, 0);
    fire(12'h006);
    fire(12'h001);
    exp_exc(0, 0, 0, 0, 0);
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      mode <= dbx_pkg::MODE_32;
      da <= (i == 0) ? 64'h1008 : (i == 1) ? 64'h1005 : 64'h1007;
      dl <= dbx_pkg::LEN_1;
      dw <= (i != 1);
      fire(12'h008);
      fire(12'h002);
      exp_exc(i == 2, dbx_pkg::VEC_DEBUG, 0, 0, 0);
    end
    wr(8'h24, 32'h00a0_0005);
    @(posedge aclk);
    da <= 64'h1003;
    dio <= 1;
    fire(12'h008);
    fire(12'h002);
    exp_exc(1, dbx_pkg::VEC_DEBUG, 0, 0, 0);
    dio <= 0;
    fire(12'h008);
    fire(12'h002);
    exp_exc(0, 0, 0, 0, 0);
    m_stat[1] = 1;
    wr(8'h24, 32'h0090_2005);
    @(posedge aclk);
    mi <= 3'h0;
    fire(12'h800);
    check("mov_blocked", mrv, 1'b0);
    exp_exc(1, dbx_pkg::VEC_DEBUG, 1, 0, 1);
    m_stat[13] = 1;
    rdr(8'h20);
    check("status", d, m_stat);
    for (int i = 4; i < 7; i++) begin
      fire(12'h001 << i);
      exp_exc(1, dbx_pkg::VEC_DEBUG, 0, 0, 0);
    end
    m_stat[15:14] = 2'h3;
    rdr(8'h20);
    check("status", d, m_stat);
    fire(12'h080);
    exp_exc(1, dbx_pkg::VEC_BP, 0, 0, 0);
    @(posedge aclk);
    fv <= 8'h0e;
    fire(12'h100);
    exp_exc(1, 8'h0e, 1, 0, 1);
    @(posedge aclk);
    iv <= 8'h20;
    rep <= 1;
    fire(12'h200);
    exp_exc(1, 8'h20, 0, 0, 1);
    @(posedge aclk);
    rep <= 0;
    fire(12'h200);
    exp_exc(1, 8'h20, 0, 0, 0);
    @(posedge aclk);
    ia <= a;
    fire(12'h101);
    exp_exc(1, dbx_pkg::VEC_DEBUG, 1, 0, 0);
    fire(12'h400);
    fire(12'h200);
    exp_exc(1, 8'h20, 0, 0, 1);
    tally_and_finish;
  end
endmodule
